// ---- logic/ctsa_pkg.sv ----
// Constants shared by the time slot assigner and its helper modules.
package ctsa_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Control register fields and reset value.
  localparam int         CTRL_ADDRESSED_BIT = 0;
  localparam int         CTRL_HARDADDR_LSB  = 8;
  localparam int         HARDADDR_WIDTH     = 5;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // Status register field positions.
  localparam int STAT_TXSLOT_LSB  = 0;
  localparam int STAT_RXSLOT_LSB  = 8;
  localparam int STAT_TXON_BIT    = 16;
  localparam int STAT_RXON_BIT    = 17;
  localparam int STAT_POWER_BIT   = 18;
  localparam int STAT_TXPROG_BIT  = 19;
  localparam int STAT_STATE_LSB   = 20;
  localparam int STAT_WORDS_BIT   = 22;
  localparam int STAT_QBITS_LSB   = 24;

  // Serial word layout, first bit sent lands in bit 7.
  localparam int WORD_BITS       = 8;
  localparam int SLOT_NUM_BITS   = 6;
  localparam int MODE_FIRST_BIT  = 7;
  localparam int MODE_SECOND_BIT = 6;
  localparam int QBITS_LSB       = 5;
  localparam int QBITS_WIDTH     = 3;

  // Slot timing counted in data clocks; the last serial shift in port clocks.
  localparam int         SLOT_CLOCKS   = 8;
  localparam int         FRAME_BITS    = 512;
  localparam logic [8:0] LAST_BIT      = 9'h1ff;
  localparam logic [3:0] LAST_SHIFT    = 4'h7;
  localparam logic [1:0] ACK_DELAY_DC  = 2'h3;

  // Synchronised pin positions.
  localparam int PIN_COUNT  = 9;
  localparam int PIN_TXFS   = 0;
  localparam int PIN_RXFS   = 1;
  localparam int PIN_DCA    = 2;
  localparam int PIN_DCB    = 3;
  localparam int PIN_PCLK   = 4;
  localparam int PIN_GSEL   = 5;
  localparam int PIN_SLOTIN = 6;
  localparam int PIN_ADDRIN = 7;
  localparam int PIN_HOOK   = 8;

  // Programming sequence states.
  typedef enum logic [1:0] {
    CTSA_WAIT    = 2'b00,
    CTSA_ARMED   = 2'b01,
    CTSA_ACKWAIT = 2'b10,
    CTSA_ACKLOW  = 2'b11
  } ctsa_state_t;

endpackage

// ---- logic/ctsa_sync_edge.sv ----
// Two-stage pin synchroniser with rise and fall detection per bit.
`timescale 1ns/100ps
module ctsa_sync_edge #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;
  logic [WIDTH-1:0] prev_r;

  // Only the second stage and beyond feed any logic.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r   <= '0;
      stable_r <= '0;
      prev_r   <= '0;
    end else begin
      meta_r   <= pinIn;
      stable_r <= meta_r;
      prev_r   <= stable_r;
    end
  end

  // Edges compare two settled stages, never the first one.
  assign level = stable_r;
  assign rise  = stable_r & ~prev_r;
  assign fall  = ~stable_r & prev_r;

endmodule // ctsa_sync_edge

// ---- logic/ctsa_slot_timer.sv ----
// Bit counter that marks one programmed eight-clock slot after a frame sync.
`timescale 1ns/100ps
module ctsa_slot_timer (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       frameRise,
  input  wire logic       dataRise,
  input  wire logic [5:0] slotNum,
  output logic            inSlot
);

  logic [8:0] bitCnt_r;
  logic       run_r;
  logic       inSlot_r;
  wire        match;

  assign match = run_r && (bitCnt_r[8:3] == slotNum);

  always_ff @(posedge clk) begin
    if (reset) begin
      bitCnt_r <= 9'h000;
      run_r    <= 1'b0;
    end else if (frameRise) begin
      bitCnt_r <= 9'h000;
      run_r    <= 1'b1;
    end else if (dataRise && run_r) begin
      bitCnt_r <= bitCnt_r + 9'h001;
      run_r    <= (bitCnt_r != ctsa_pkg::LAST_BIT);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      inSlot_r <= 1'b0;
    end else begin
      inSlot_r <= match;
    end
  end

  assign inSlot = inSlot_r;

endmodule // ctsa_slot_timer

// ---- logic/ctsa_slot_assigner.sv ----
// Codec time slot assigner: serial port, slot timing, power and hook mux.
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps

// Summary of operation
// - Mode 00 loads both slots, power high
// - Mode 10 loads receive slot only
// - Mode 01 loads transmit slot only
// - Mode 11 powers down, ignores slot bits
// - Power rests high, set on programming
// - Hook output inverted during transmit slot
// - Hook mux continues after power down
// - Frame sync rise marks slot zero
// - Each slot spans eight data clocks
// - Framing bit falls after all slots
// - Serial bits sampled at port clock fall
// - Select low discards partial words
// - Eight port clocks give two words
// - Addressed mode compares five address bits
// - Acknowledge low after next frame sync
// - Acknowledge falls on third data clock
// - Program loads at next frame sync
// - Following frame sync releases and resets
// - Unaddressed mode accepts whenever selected
// - Serial order is MSB first
// - Slot number counts slots after sync
// - Enables high eight data clocks
module ctsa_slot_assigner (
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave.
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWritedata,
  input  wire logic [3:0]  avsByteenable,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  // Codec and line side.
  input  wire logic        tx_frame_sync,
  input  wire logic        rx_frame_sync,
  input  wire logic        data_clock_a,
  input  wire logic        data_clock_b,
  input  wire logic        hook_in,
  output logic             tx_slot_enable,
  output logic             rx_slot_enable,
  output logic             channel_power_ctl,
  output logic             hook_out_inverted,
  output logic             hook_out_inverted_oe_n,
  output logic      [2:0]  status_bit,
  // Serial programming port.
  input  wire logic        portClock,
  input  wire logic        groupSelect,
  input  wire logic        slot_word_in,
  input  wire logic        addrWordIn,
  output logic             clearToSend,
  output logic             clearToSend_oe_n
);

  // Synchronised pins.
  logic [ctsa_pkg::PIN_COUNT-1:0] pinLevel;
  logic [ctsa_pkg::PIN_COUNT-1:0] pinRise;
  logic [ctsa_pkg::PIN_COUNT-1:0] pinFall;

  // Register file.
  logic [31:0] ctrl_r;
  logic [31:0] readdata_r;
  logic        waitreq_r;

  // Serial port.
  logic [7:0]  slotShift_r;
  logic [7:0]  addrShift_r;
  logic [3:0]  shiftCnt_r;
  logic        wordsDone_r;

  // Programmed state.
  ctsa_pkg::ctsa_state_t state_r;
  ctsa_pkg::ctsa_state_t state_nxt;
  logic [5:0]  txSlot_r;
  logic [5:0]  rxSlot_r;
  logic        txOn_r;
  logic        rxOn_r;
  logic        txProg_r;
  logic        power_r;
  logic [2:0]  qBits_r;
  logic [1:0]  dcCnt_r;
  logic        ackLow_r;

  // Output flops.
  logic        txEn_r;
  logic        rxEn_r;
  logic        hookOe_n_r;
  logic        odData_r;

  logic        txInSlot;
  logic        rxInSlot;

  // Pins arrive from other clocks, so every one is synchronised.
  ctsa_sync_edge #(
    .WIDTH (ctsa_pkg::PIN_COUNT)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .pinIn ({hook_in, addrWordIn, slot_word_in, groupSelect, portClock,
             data_clock_b, data_clock_a, rx_frame_sync, tx_frame_sync}),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  // Named views of the synchronised pins.
  wire txFsRise = pinRise[ctsa_pkg::PIN_TXFS];
  wire rxFsRise = pinRise[ctsa_pkg::PIN_RXFS];
  wire dcARise  = pinRise[ctsa_pkg::PIN_DCA];
  wire dcBRise  = pinRise[ctsa_pkg::PIN_DCB];
  wire portFall = pinFall[ctsa_pkg::PIN_PCLK];
  wire selected = pinLevel[ctsa_pkg::PIN_GSEL];
  wire slotBit  = pinLevel[ctsa_pkg::PIN_SLOTIN];
  wire addrBit  = pinLevel[ctsa_pkg::PIN_ADDRIN];
  wire hookHigh = pinLevel[ctsa_pkg::PIN_HOOK];

  // Bus request decode; a request is taken on the cycle it is answered.
  wire busReq     = avsRead | avsWrite;
  wire busTake    = busReq & ~waitreq_r;
  wire hitCtrl    = (avsAddress == ctsa_pkg::CTRL_OFFSET);
  wire hitStatus  = (avsAddress == ctsa_pkg::STATUS_OFFSET);
  wire ctrlWrite  = busTake & avsWrite & hitCtrl;

  // Byte lanes merge into the control register; unmapped offsets read zero.
  wire [31:0] laneMask = {{8{avsByteenable[3]}}, {8{avsByteenable[2]}},
                          {8{avsByteenable[1]}}, {8{avsByteenable[0]}}};
  wire [31:0] ctrlMerged = (ctrl_r & ~laneMask) | (avsWritedata & laneMask);

  wire addressedMode = ctrl_r[ctsa_pkg::CTRL_ADDRESSED_BIT];
  wire [4:0] hardAddress =
    ctrl_r[ctsa_pkg::CTRL_HARDADDR_LSB +: ctsa_pkg::HARDADDR_WIDTH];

  // Status word shows the programmed state of the channel.
  wire [31:0] statusWord =
    (32'(txSlot_r)    << ctsa_pkg::STAT_TXSLOT_LSB) |
    (32'(rxSlot_r)    << ctsa_pkg::STAT_RXSLOT_LSB) |
    (32'(txOn_r)      << ctsa_pkg::STAT_TXON_BIT)   |
    (32'(rxOn_r)      << ctsa_pkg::STAT_RXON_BIT)   |
    (32'(power_r)     << ctsa_pkg::STAT_POWER_BIT)  |
    (32'(txProg_r)    << ctsa_pkg::STAT_TXPROG_BIT) |
    (32'(state_r)     << ctsa_pkg::STAT_STATE_LSB)  |
    (32'(wordsDone_r) << ctsa_pkg::STAT_WORDS_BIT)  |
    (32'(qBits_r)     << ctsa_pkg::STAT_QBITS_LSB);

  wire [31:0] readMux = hitCtrl   ? ctrl_r     :
                        hitStatus ? statusWord : 32'h0000_0000;

  // One wait cycle per request, then a single answer cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      waitreq_r  <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end else begin
      waitreq_r  <= ~(busReq & waitreq_r);
      readdata_r <= (busReq & waitreq_r) ? readMux : readdata_r;
    end
  end

  // Control register: addressing mode and the strapped device address.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= ctsa_pkg::CTRL_RESET;
    end else if (ctrlWrite) begin
      ctrl_r <= ctrlMerged;
    end
  end

  // Word pair acceptance, with or without the address compare.
  // five-bit address compare
  wire addrMatch = (addrShift_r[4:0] == hardAddress);
  wire accepted  = wordsDone_r & (~addressedMode | addrMatch);

  // Non-selected devices drop their words at the frame after the load;
  // the selected one drops them when its acknowledge is released.
  // return to waiting
  wire returnReady = txFsRise &
    (((state_r == ctsa_pkg::CTSA_WAIT) & wordsDone_r & ~accepted) |
     (state_r == ctsa_pkg::CTSA_ACKLOW));

  // Serial shift; data is stable at the port clock fall since the host
  // changes it at the rise, so both inputs are sampled there.
  // sample at falling edge
  always_ff @(posedge clk) begin
    if (reset || !selected || returnReady) begin
      shiftCnt_r  <= 4'h0;
      wordsDone_r <= 1'b0;
      slotShift_r <= 8'h00;
      addrShift_r <= 8'h00;
    end else if (portFall && !wordsDone_r) begin
      slotShift_r <= {slotShift_r[6:0], slotBit};
      addrShift_r <= {addrShift_r[6:0], addrBit};
      shiftCnt_r  <= shiftCnt_r + 4'h1;
      wordsDone_r <= (shiftCnt_r == ctsa_pkg::LAST_SHIFT);
    end
  end

  wire modeFirst  = slotShift_r[ctsa_pkg::MODE_FIRST_BIT];
  wire modeSecond = slotShift_r[ctsa_pkg::MODE_SECOND_BIT];
  wire [5:0] newSlot = slotShift_r[ctsa_pkg::SLOT_NUM_BITS-1:0];
  wire [2:0] newQ    =
    addrShift_r[ctsa_pkg::QBITS_LSB +: ctsa_pkg::QBITS_WIDTH];

  // Programming sequence next state.
  // synchronised completion flag
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ctsa_pkg::CTSA_WAIT: begin
        if (accepted) begin
          state_nxt = ctsa_pkg::CTSA_ARMED;
        end
      end
      ctsa_pkg::CTSA_ARMED: begin
        if (!selected) begin
          state_nxt = ctsa_pkg::CTSA_WAIT;
        end else if (txFsRise) begin
          state_nxt = ctsa_pkg::CTSA_ACKWAIT;
        end
      end
      ctsa_pkg::CTSA_ACKWAIT: begin
        if (txFsRise) begin
          state_nxt = ctsa_pkg::CTSA_WAIT;
        end else if (dcARise && dcCnt_r == ctsa_pkg::ACK_DELAY_DC - 2'h1) begin
          state_nxt = ctsa_pkg::CTSA_ACKLOW;
        end
      end
      ctsa_pkg::CTSA_ACKLOW: begin
        if (txFsRise) begin
          state_nxt = ctsa_pkg::CTSA_WAIT;
        end
      end
      default: state_nxt = ctsa_pkg::CTSA_WAIT;
    endcase
  end

  wire loadNow = (state_r == ctsa_pkg::CTSA_ARMED) & selected & txFsRise;

  // Sequence state, data clock count and the acknowledge drive.
  // acknowledge after frame sync
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r  <= ctsa_pkg::CTSA_WAIT;
      dcCnt_r  <= 2'h0;
      ackLow_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      dcCnt_r  <= loadNow ? 2'h0 :
                  (dcARise ? dcCnt_r + 2'h1 : dcCnt_r);
      ackLow_r <= (state_nxt == ctsa_pkg::CTSA_ACKLOW);
    end
  end

  // Program load at the frame sync leading edge. The slot bits are kept
  // on power down so the hook mux keeps its old transmit slot.
  // load at frame sync
  always_ff @(posedge clk) begin
    if (reset) begin
      txSlot_r <= 6'h00;
      rxSlot_r <= 6'h00;
      txOn_r   <= 1'b0;
      rxOn_r   <= 1'b0;
      txProg_r <= 1'b0;
      power_r  <= 1'b1;
      qBits_r  <= 3'h0;
    end else if (loadNow) begin
      qBits_r <= newQ;
      case ({modeFirst, modeSecond})
        2'b00: begin
          txSlot_r <= newSlot;
          rxSlot_r <= newSlot;
          txOn_r   <= 1'b1;
          rxOn_r   <= 1'b1;
          txProg_r <= 1'b1;
          power_r  <= 1'b1;
        end
        2'b10: begin
          rxSlot_r <= newSlot;
          rxOn_r   <= 1'b1;
          power_r  <= 1'b1;
        end
        2'b01: begin
          txSlot_r <= newSlot;
          txOn_r   <= 1'b1;
          txProg_r <= 1'b1;
          power_r  <= 1'b1;
        end
        default: begin
          txOn_r   <= 1'b0;
          power_r  <= 1'b0;
        end
      endcase
    end
  end

  // Transmit and receive slot timing, each from its own frame and clock.
  // slot number in slots
  ctsa_slot_timer u_tx_timer (
    .clk       (clk),
    .reset     (reset),
    .frameRise (txFsRise),
    .dataRise  (dcARise),
    .slotNum   (txSlot_r),
    .inSlot    (txInSlot)
  );

  ctsa_slot_timer u_rx_timer (
    .clk       (clk),
    .reset     (reset),
    .frameRise (rxFsRise),
    .dataRise  (dcBRise),
    .slotNum   (rxSlot_r),
    .inSlot    (rxInSlot)
  );

  // Registered outputs; the hook line is pulled low only when off hook.
  // inverted hook in slot
  always_ff @(posedge clk) begin
    if (reset) begin
      txEn_r     <= 1'b0;
      rxEn_r     <= 1'b0;
      hookOe_n_r <= 1'b1;
      odData_r   <= 1'b0;
    end else begin
      txEn_r     <= txInSlot & txOn_r;
      rxEn_r     <= rxInSlot & rxOn_r;
      hookOe_n_r <= ~(txInSlot & txProg_r & hookHigh);
      odData_r   <= 1'b0;
    end
  end

  assign avsReaddata            = readdata_r;
  assign avsWaitrequest         = waitreq_r;
  assign tx_slot_enable         = txEn_r;
  assign rx_slot_enable         = rxEn_r;
  assign channel_power_ctl      = power_r;
  assign hook_out_inverted      = odData_r;
  assign hook_out_inverted_oe_n = hookOe_n_r;
  assign status_bit             = qBits_r;
  assign clearToSend            = odData_r;
  assign clearToSend_oe_n       = ~ackLow_r;

endmodule // ctsa_slot_assigner

// ---- dv/ctsa_slot_assigner_props.sv ----
// Concurrent checks on the pins of the slot assigner.
`timescale 1ns/100ps
module ctsa_slot_assigner_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       avsRead,
  input wire logic       avsWrite,
  input wire logic       avsWaitrequest,
  input wire logic       tx_frame_sync,
  input wire logic       data_clock_a,
  input wire logic       data_clock_b,
  input wire logic       tx_slot_enable,
  input wire logic       rx_slot_enable,
  input wire logic       channel_power_ctl,
  input wire logic       hook_out_inverted,
  input wire logic [2:0] status_bit,
  input wire logic       clearToSend,
  input wire logic       clearToSend_oe_n
);
  logic [2:0] syn1, syn2, syn3;
  logic [3:0] sinceFs, dcaCnt, txW, rxW;
  wire        fsRise  = syn2[0] & ~syn3[0];
  wire        dcaRise = syn2[1] & ~syn3[1];
  wire        dcbRise = syn2[2] & ~syn3[2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Own copy of the pin sync, so the counts line up with what the block sees.
  always_ff @(posedge clk) begin
    syn1 <= reset ? 3'h0 : {data_clock_b, data_clock_a, tx_frame_sync};
    syn2 <= reset ? 3'h0 : syn1;
    syn3 <= reset ? 3'h0 : syn2;
  end
  // Counters saturate, so a stalled data clock cannot wrap them.
  always_ff @(posedge clk) begin
    sinceFs <= (reset | fsRise) ? 4'h0 : sinceFs + {3'h0, sinceFs != 4'hf};
    dcaCnt  <= (reset | fsRise) ? 4'h0
             : dcaCnt + {3'h0, dcaRise && dcaCnt != 4'hf};
    txW <= !tx_slot_enable ? 4'h0 : txW + {3'h0, dcaRise && txW != 4'hf};
    rxW <= !rx_slot_enable ? 4'h0 : rxW + {3'h0, dcbRise && rxW != 4'hf};
  end
  a_bus_one_wait: assert property ($rose(avsRead || avsWrite) |->
    avsWaitrequest ##1 !avsWaitrequest ##1 avsWaitrequest)
    else $error("bus answer not after one wait cycle");
  a_tx_width: assert property ($fell(tx_slot_enable) |-> txW == 4'h8)
    else $error("transmit enable not eight data clocks");
  a_rx_width: assert property ($fell(rx_slot_enable) |-> rxW == 4'h8)
    else $error("receive enable not eight data clocks");
  a_tx_no_overrun: assert property (tx_slot_enable |-> txW <= 4'h8)
    else $error("transmit enable overran its slot");
  a_ack_third: assert property (
    $fell(clearToSend_oe_n) |-> dcaCnt == 4'h3)
    else $error("acknowledge fell on the wrong data clock");
  a_ack_release: assert property (!clearToSend_oe_n && fsRise |->
    ##[1:3] clearToSend_oe_n)
    else $error("acknowledge not released at frame sync");
  a_power_at_fs: assert property (
    !$stable(channel_power_ctl) |-> sinceFs <= 4'h4)
    else $error("power control changed away from frame sync");
  a_status_at_fs: assert property (!$stable(status_bit) |->
    sinceFs <= 4'h4)
    else $error("status bits changed away from frame sync");
  a_down_tx_off: assert property (
    !channel_power_ctl |=> !tx_slot_enable)
    else $error("transmit enable high while powered down");
  a_drain_low: assert property (
    !hook_out_inverted && !clearToSend)
    else $error("open-drain data not low");
  c_ack: cover property ($fell(clearToSend_oe_n));
  c_down: cover property ($fell(channel_power_ctl));
  c_tx: cover property ($fell(tx_slot_enable));
endmodule // ctsa_slot_assigner_props

bind ctsa_slot_assigner ctsa_slot_assigner_props ctsa_slot_assigner_props_inst (
  .clk, .reset, .avsRead, .avsWrite, .avsWaitrequest, .tx_frame_sync,
  .data_clock_a, .data_clock_b, .tx_slot_enable, .rx_slot_enable,
  .channel_power_ctl, .hook_out_inverted, .status_bit, .clearToSend,
  .clearToSend_oe_n);

// ---- dv/ctsa_host_model.sv ----
// Behavioural host that shifts slot and address words into the serial port.
`timescale 1ns/100ps
module ctsa_host_model (
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [7:0] slotWord,
  input  wire logic [7:0] addrWord,
  input  wire logic [3:0] bitCount,
  input  wire logic       ackLine,
  output logic            portClock,
  output logic            groupSelect,
  output logic            slotOut,
  output logic            addrOut,
  output logic            busy
);
  int n;
  // One load per start pulse; fewer than eight bits aborts the load.
  initial begin
    {portClock, groupSelect, slotOut, busy} = 4'h0;
    addrOut = 1'b1;
    forever begin
      @(posedge clk);
      if (start === 1'b1) begin
        busy <= 1'b1;
        n = 0;
        // A low ack is a fault; start only once released.
        while (ackLine !== 1'b1 && n < 5000) begin
          @(posedge clk);
          n++;
        end
        groupSelect <= 1'b1;
        repeat (2) @(posedge clk);
        // Bits change at the rise, MSB first.
        for (int i = 0; i < bitCount; i++) begin
          slotOut   <= slotWord[7-i];
          addrOut   <= addrWord[7-i];
          portClock <= 1'b1;
          repeat (4) @(posedge clk);
          portClock <= 1'b0;
          repeat (4) @(posedge clk);
        end
        // Released data lines show the inverse, never a stale value.
        slotOut <= ~slotOut;
        addrOut <= ~addrOut;
        n = 0;
        // Hold select until ack falls and returns.
        while (bitCount == 4'h8 && ackLine !== 1'b0 && n < 5000) begin
          @(posedge clk);
          n++;
        end
        while (bitCount == 4'h8 && ackLine !== 1'b1 && n < 10000) begin
          @(posedge clk);
          n++;
        end
        groupSelect <= 1'b0;
        repeat (2) @(posedge clk);
        busy <= 1'b0;
      end
    end
  end
endmodule // ctsa_host_model

// ---- dv/testbench.sv ----
// Self-checking bench for the codec time slot assigner.
`timescale 1ns/100ps
module testbench;
  logic        clk, reset, avsRead, avsWrite, avsWaitrequest;
  logic [3:0]  avsAddress, hBits;
  logic [31:0] avsWritedata, avsReaddata, rd;
  logic        fs, dc, hookIn, tx_slot_enable, rx_slot_enable;
  logic        channel_power_ctl, hook_out_inverted, hook_out_inverted_oe_n;
  logic [2:0]  status_bit, qExp, pQ, dcCnt;
  logic        portClock, groupSelect, slot_word_in, addrWordIn;
  logic        clearToSend, clearToSend_oe_n, ackLine, hStart, hBusy;
  logic [7:0]  hSlot, hAddr, pWord, sw;
  logic [9:0]  bitCnt, frameBits;
  logic [5:0]  txSlot, rxSlot;
  logic        txOn, rxOn, hookOn, power, ackFrame, pValid, pAcc;
  int          err_count, tests_run, cyc;
  // Open-drain acknowledge with its pull-up.
  assign ackLine = clearToSend_oe_n ? 1'b1 : clearToSend;

  ctsa_slot_assigner ctsa_slot_assigner_inst (
    .clk, .reset, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsByteenable(4'hf), .avsReaddata, .avsWaitrequest,
    .tx_frame_sync(fs), .rx_frame_sync(fs), .data_clock_a(dc),
    .data_clock_b(dc), .hook_in(hookIn), .tx_slot_enable, .rx_slot_enable,
    .channel_power_ctl, .hook_out_inverted, .hook_out_inverted_oe_n,
    .status_bit, .portClock, .groupSelect, .slot_word_in, .addrWordIn,
    .clearToSend, .clearToSend_oe_n);

  ctsa_host_model ctsa_host_model_inst (
    .clk, .start(hStart), .slotWord(hSlot), .addrWord(hAddr),
    .bitCount(hBits), .ackLine, .portClock, .groupSelect,
    .slotOut(slot_word_in), .addrOut(addrWordIn), .busy(hBusy));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic in_slot(input logic on, input logic [5:0] s,
                                   input logic [9:0] b);
    return on && (b[9:3] == {1'b0, s});
  endfunction

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic load_program();
    qExp = pQ;
    case (pWord[7:6])
      2'b00: {txOn, rxOn, hookOn, power, txSlot, rxSlot} =
               {4'hf, pWord[5:0], pWord[5:0]};
      2'b10: {rxOn, power, rxSlot} = {2'h3, pWord[5:0]};
      2'b01: {txOn, hookOn, power, txSlot} = {3'h7, pWord[5:0]};
      default: {txOn, power} = 2'h0;
    endcase
  endtask

  // Data clock of 200 ns; frame sync rises mid-bit, clear of clock edges.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    dcCnt <= dcCnt + 3'h1;
    if (dcCnt == 3'h7) begin
      dc <= 1'b1;
      bitCnt <= bitCnt + 10'h1;
    end
    if (dcCnt == 3'h3) dc <= 1'b0;
    if (dcCnt == 3'h1 && bitCnt == 10'h4) fs <= 1'b0;
    if (dcCnt == 3'h1 && bitCnt == frameBits) begin
      fs <= 1'b1;
      bitCnt <= 10'h0;
      hookIn <= 1'($urandom);
      ackFrame = pValid && pAcc;
      if (ackFrame) load_program();
      pValid = 1'b0;
    end
    if (dcCnt == 3'h5 && bitCnt != 10'h0 && !reset) begin
      chk("tx_en", in_slot(txOn, txSlot, bitCnt), tx_slot_enable);
      chk("rx_en", in_slot(rxOn, rxSlot, bitCnt), rx_slot_enable);
      chk("power", power, channel_power_ctl);
      chk("hook", !(hookIn && in_slot(hookOn, txSlot, bitCnt)),
          hook_out_inverted_oe_n);
      chk("ack", !(ackFrame && bitCnt >= 10'h3), ackLine);
      chk("status", qExp, status_bit);
    end
    if (cyc == 60000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic avs(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_bit1();
    do begin
      @(posedge clk);
    end while (!(bitCnt == 10'h1 && dcCnt == 3'h2));
  endtask

  // Starts the host early in a frame, so the load lands at the next sync.
  task automatic host_load(input logic [7:0] s, input logic [7:0] a,
                           input logic [3:0] nb, input logic acc);
    wait_bit1();
    hSlot <= s;
    hAddr <= a;
    hBits <= nb;
    hStart <= 1'b1;
    @(posedge clk);
    hStart <= 1'b0;
    {pWord, pQ, pAcc, pValid} = {s, a[7:5], acc, nb == 4'h8};
    repeat (2) @(posedge clk);
    while (hBusy !== 1'b0) begin
      @(posedge clk);
    end
  endtask

  initial begin
    void'($urandom(32'h7427a79d));
    {avsRead, avsWrite, fs, dc, hookIn, hStart, txOn, rxOn} = 8'h00;
    {hookOn, ackFrame, pValid, pAcc} = 4'h0;
    {avsAddress, avsWritedata, hSlot, hAddr, hBits} = '0;
    {dcCnt, qExp, pQ, txSlot, rxSlot, pWord} = '0;
    {bitCnt, frameBits, power} = {10'h0, 10'h40, 1'b1};
    {cyc, err_count, tests_run} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    avs(1'b0, ctsa_pkg::CTRL_OFFSET, 32'h0, rd);
    chk("ctrl_reset", ctsa_pkg::CTRL_RESET, rd);
    avs(1'b0, ctsa_pkg::STATUS_OFFSET, 32'h0, rd);
    chk("stat_power", 1'b1, rd[ctsa_pkg::STAT_POWER_BIT]);
    avs(1'b0, 4'h8, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    avs(1'b1, ctsa_pkg::CTRL_OFFSET, 32'h0000_0b01, rd);
    avs(1'b0, ctsa_pkg::CTRL_OFFSET, 32'h0, rd);
    chk("ctrl_rw", 32'h0000_0b01, rd);
    // Matching address loads, a foreign address is ignored.
    host_load(8'h45, 8'h6b, 4'h8, 1'b1);
    host_load(8'h02, 8'ha0 | 8'h0c, 4'h8, 1'b0);
    avs(1'b1, ctsa_pkg::CTRL_OFFSET, 32'h0, rd);
    // A partial word is dropped with the select.
    host_load(8'hc0, 8'hff, 4'h3, 1'b0);
    // Every mode in turn, random slot, status and address.
    for (int i = 0; i < 8; i++) begin
      sw[7:6] = (i % 4 == 0) ? 2'b00 : (i % 4 == 1) ? 2'b10
              : (i % 4 == 2) ? 2'b01 : 2'b11;
      sw[5:0] = (sw[7:6] == 2'b11) ? 6'($urandom) : {3'h0, 3'($urandom)};
      host_load(sw, 8'($urandom), 4'h8, 1'b1);
    end
    // Highest slot in a full-length frame.
    frameBits = 10'd512;
    host_load(8'h3f, 8'($urandom), 4'h8, 1'b1);
    wait_bit1();
    avs(1'b0, ctsa_pkg::STATUS_OFFSET, 32'h0, rd);
    chk("stat_txslot", 6'h3f, rd[5:0]);
    wait_bit1();
    wrap_up();
  end
endmodule // testbench
